// ==== hw/adtg_addr_latch.sv ====
`timescale 1ns/100ps
`default_nettype none
module adtg_addr_latch #(
  parameter int AW = adtg_pkg::ADTG_AW
) (
  // Clock and reset
  input  wire logic   sys_clk,
  input  wire logic   srst,
  // Latch control
  adtg_latch_if.lat   lif
);
  import adtg_pkg::*;

  typedef struct packed {
    logic [AW-1:0] addr;
  } adtg_lat_s;

  adtg_lat_s r;
  adtg_lat_s next_r;

  // Closed by default: only an open cycle takes a new address
  always_comb begin
    next_r = r;
    if (lif.open) begin
      next_r.addr = lif.addr_in;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r.addr <= AW'(ADTG_ADDR_RST);
    end else begin
      r <= next_r;
    end
  end

  assign lif.addr_q = r.addr;
endmodule
`default_nettype wire

// ==== hw/adtg_latch_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// Latch control travelling between the tracker and the address holder
interface adtg_latch_if #(
  parameter int AW = 32
);
  logic          open;
  logic [AW-1:0] addr_in;
  logic [AW-1:0] addr_q;
  modport ctl (output open, output addr_in, input addr_q);
  modport lat (input open, input addr_in, output addr_q);
endinterface
`default_nettype wire

// ==== hw/adtg_pkg.sv ====
`default_nettype none
package adtg_pkg;
  // ------------------------------------------------------------
  // Widths and encodings
  // ------------------------------------------------------------
  localparam int          ADTG_AW         = 32;
  localparam logic [1:0]  ADTG_SIZE_BURST = 2'h3;  // Size code of a line burst
  localparam logic [1:0]  ADTG_BEAT_FIRST = 2'h0;
  localparam logic [1:0]  ADTG_BEAT_LAST  = 2'h3;  // Fourth longword of a burst

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [31:0] ADTG_ADDR_RST   = 32'h0000_0000;

  // ------------------------------------------------------------
  // Tracking states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ADTG_IDLE,
    ADTG_ADDR,
    ADTG_DATA
  } adtg_state_e;
endpackage
`default_nettype wire

// ==== hw/adtg_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module adtg_top #(
  parameter int AW = adtg_pkg::ADTG_AW
) (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            srst,
  // Mode straps
  input  wire logic            wait_insert,
  input  wire logic            sync_mode,
  // Processor multiplexed bus
  input  wire logic [AW-1:0]   ad_in,
  input  wire logic [1:0]      xfer_size,
  input  wire logic            transfer_start_strobe,
  input  wire logic            transfer_ack,
  input  wire logic            transfer_err_ack,
  input  wire logic            burst_inhibit,
  input  wire logic            bus_grant,
  // Board side
  output logic [AW-1:0]        addr_out,
  output logic                 addr_oe,
  output logic                 ts_out,
  output logic                 tip_out,
  output logic                 tip_oe,
  output logic                 latch_open_ctl,
  output logic                 start_hold_flag,
  output logic                 data_wait,
  output logic                 retry_berr
);
  import adtg_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    adtg_state_e state;
    logic [1:0]  beat;
    logic        burst;
    logic        ts_out;
    logic        tip;
    logic        own;
    logic        latch_open;
    logic        hold;
    logic        data_wait;
    logic        retry_berr;
  } adtg_st_s;

  adtg_st_s r;
  adtg_st_s next_r;

  logic ts_qual;
  logic start;
  logic beat_done;
  logic retry;
  logic last_beat;

  adtg_latch_if #(.AW(AW)) lif ();

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // Strobe only counts while this master owns the bus
  assign ts_qual   = transfer_start_strobe & bus_grant;
  // Synchronous scheme starts from the delayed strobe
  assign start     = sync_mode ? r.ts_out : ts_qual;
  assign beat_done = transfer_ack | transfer_err_ack;
  assign retry     = transfer_ack & transfer_err_ack;
  // Any error, inhibit or plain cycle ends the transaction early
  assign last_beat = transfer_err_ack | burst_inhibit | ~r.burst
                   | (r.beat == ADTG_BEAT_LAST);

  // ------------------------------------------------------------
  // Address latch control
  // ------------------------------------------------------------
  // Opened only while the tracker is not in a data phase, so a late
  // strobe edge inside a data phase cannot glitch the address away
  always_comb begin
    lif.open    = (ts_qual & (r.state != ADTG_DATA))
                | (r.state == ADTG_ADDR);
    lif.addr_in = ad_in;
  end

  adtg_addr_latch #(.AW(AW)) u_latch (
    .sys_clk (sys_clk),
    .srst    (srst),
    .lif     (lif)
  );

  // ------------------------------------------------------------
  // Tracker
  // ------------------------------------------------------------
  always_comb begin
    next_r            = r;
    next_r.ts_out     = ts_qual;
    next_r.latch_open = lif.open;
    next_r.data_wait  = 1'b0;
    next_r.retry_berr = 1'b0;
    // Hold flag set by strobe, kept until acknowledge or error
    next_r.hold       = ts_qual | (r.hold & ~beat_done);
    unique case (r.state)
      ADTG_IDLE: begin
        if (start) begin
          next_r.beat  = ADTG_BEAT_FIRST;
          next_r.burst = (xfer_size == ADTG_SIZE_BURST);
          // Wait insert stretches the address phase by a cycle
          next_r.state = wait_insert ? ADTG_ADDR : ADTG_DATA;
        end
      end
      ADTG_ADDR: begin
        next_r.state = ADTG_DATA;
      end
      ADTG_DATA: begin
        next_r.data_wait = ~beat_done;
        if (beat_done) begin
          // Retry past the first beat is reported as bus error
          next_r.retry_berr = retry & (r.beat != ADTG_BEAT_FIRST);
          if (last_beat) begin
            // Back to back only without wait insert; otherwise an idle gap
            if (start && !wait_insert) begin
              next_r.beat  = ADTG_BEAT_FIRST;
              next_r.burst = (xfer_size == ADTG_SIZE_BURST);
              next_r.state = ADTG_DATA;
            end else begin
              next_r.state = ADTG_IDLE;
            end
          end else begin
            next_r.beat = r.beat + 2'h1;
          end
        end
      end
    endcase
    // Active for the whole transaction, dropped only when idle
    next_r.tip = (next_r.state != ADTG_IDLE) | (ts_qual & ~sync_mode);
    // Keep driving while granted or while a cycle is still finishing
    next_r.own = bus_grant | (next_r.state != ADTG_IDLE);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // Reset leaves the tracker idle with the latch closed
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_comb begin
    addr_out        = lif.addr_q;
    addr_oe         = r.own;
    ts_out          = r.ts_out;
    tip_out         = r.tip;
    tip_oe          = r.own;
    latch_open_ctl  = r.latch_open;
    start_hold_flag = r.hold;
    data_wait       = r.data_wait;
    retry_berr      = r.retry_berr;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_addr_phase_open;
    @(posedge sys_clk) disable iff (srst)
      (r.state == ADTG_ADDR) |-> lif.open ##1 (r.state == ADTG_DATA);
  endproperty
  a_addr_phase_open: assert property (p_addr_phase_open)
    else $error("latch not open through address phase");

  property p_no_wait_data;
    @(posedge sys_clk) disable iff (srst)
      (!wait_insert && start && r.state == ADTG_IDLE) |=> (r.state == ADTG_DATA) && tip_out;
  endproperty
  a_no_wait_data: assert property (p_no_wait_data)
    else $error("data phase not entered after short address phase");

  property p_idle_gap;
    @(posedge sys_clk) disable iff (srst)
      (wait_insert && r.state == ADTG_DATA && beat_done && last_beat) |=> !tip_out;
  endproperty
  a_idle_gap: assert property (p_idle_gap)
    else $error("no idle cycle between transactions");

  property p_four_beats;
    @(posedge sys_clk) disable iff (srst)
      (r.state == ADTG_DATA && r.beat == ADTG_BEAT_LAST && beat_done)
        |=> (r.state != ADTG_DATA) || (r.beat == ADTG_BEAT_FIRST);
  endproperty
  a_four_beats: assert property (p_four_beats)
    else $error("burst ran past four longwords");

  property p_retry_berr;
    @(posedge sys_clk) disable iff (srst)
      (r.state == ADTG_DATA && retry && r.beat != ADTG_BEAT_FIRST) |=> retry_berr;
  endproperty
  a_retry_berr: assert property (p_retry_berr)
    else $error("late burst retry not flagged as bus error");

  property p_ts_delay;
    @(posedge sys_clk) disable iff (srst)
      ts_qual |=> ts_out;
  endproperty
  a_ts_delay: assert property (p_ts_delay)
    else $error("start strobe not passed on one clock later");

  property p_two_waits;
    @(posedge sys_clk) disable iff (srst)
      (sync_mode && wait_insert && ts_qual && r.state == ADTG_IDLE && !r.ts_out)
        |=> (r.state == ADTG_IDLE) ##1 (r.state == ADTG_ADDR) ##1 (r.state == ADTG_DATA);
  endproperty
  a_two_waits: assert property (p_two_waits)
    else $error("synchronous wait insert did not give two waits");

  property p_wait_state;
    @(posedge sys_clk) disable iff (srst)
      (r.state == ADTG_DATA && !beat_done) |=> data_wait && tip_out;
  endproperty
  a_wait_state: assert property (p_wait_state)
    else $error("wait-state not flagged");
endmodule
`default_nettype wire

// ==== verification/address_demux_tip_generator_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module address_demux_tip_generator_bench;
  import adtg_pkg::*;
  typedef struct {logic w, s; logic [1:0] sz, ws; logic inh; logic [2:0] eb;} adtg_row_s;
  logic        sys_clk, srst, wait_insert, sync_mode, transfer_start_strobe;
  logic        transfer_ack, transfer_err_ack, burst_inhibit, bus_grant;
  logic [31:0] ad_in, addr_out;
  logic [1:0]  xfer_size, ws;
  logic [2:0]  err_beat;
  logic        addr_oe, ts_out, tip_out, tip_oe, latch_open_ctl;
  logic        start_hold_flag, data_wait, retry_berr;
  int          fail_count, num_checks;
  // Ordinary cases: straps, size, wait-states, inhibit, retry beat
  adtg_row_s rows [7] = '{'{0, 0, 2'h0, 2'h0, 0, 3'h0}, '{1, 0, 2'h3, 2'h1, 0, 3'h0},
    '{1, 1, 2'h0, 2'h0, 0, 3'h0}, '{0, 1, 2'h3, 2'h0, 0, 3'h0}, '{0, 0, 2'h3, 2'h2, 1, 3'h0},
    '{0, 0, 2'h3, 2'h0, 0, 3'h2}, '{0, 0, 2'h3, 2'h0, 0, 3'h1}};

  adtg_top i_dut (.sys_clk(sys_clk), .srst(srst), .wait_insert(wait_insert),
    .sync_mode(sync_mode), .ad_in(ad_in), .xfer_size(xfer_size),
    .transfer_start_strobe(transfer_start_strobe), .transfer_ack(transfer_ack),
    .transfer_err_ack(transfer_err_ack), .burst_inhibit(burst_inhibit),
    .bus_grant(bus_grant), .addr_out(addr_out), .addr_oe(addr_oe), .ts_out(ts_out),
    .tip_out(tip_out), .tip_oe(tip_oe), .latch_open_ctl(latch_open_ctl),
    .start_hold_flag(start_hold_flag), .data_wait(data_wait), .retry_berr(retry_berr));
  adtg_mem_model i_mem (.sys_clk(sys_clk), .srst(srst), .wait_insert(wait_insert),
    .tip_out(tip_out), .ws(ws), .err_beat(err_beat), .transfer_ack(transfer_ack),
    .transfer_err_ack(transfer_err_ack));

  // 40 MHz bus clock
  always #12.5 sys_clk = ~sys_clk;

  // ------------------------------------------------------------
  // Compare and closing
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One transaction; the processor keeps the address up until data moves
  task automatic run(input adtg_row_s r, input logic [31:0] a);
    int tipc, dwc, tsc, rbc, first, beats;
    logic acked;
    tipc = 0; dwc = 0; tsc = 0; rbc = 0; first = -1; acked = 0;
    beats = r.inh ? 1 : (r.eb != 0) ? int'(r.eb) : (r.sz == ADTG_SIZE_BURST) ? 4 : 1;
    // Straps change on an edge, with the bus idle
    @(posedge sys_clk);
    wait_insert <= r.w;
    sync_mode <= r.s;
    ws <= r.ws;
    burst_inhibit <= r.inh;
    err_beat <= r.eb;
    repeat (3) @(posedge sys_clk);
    transfer_start_strobe <= 1'b1;
    ad_in <= a;
    xfer_size <= r.sz;
    for (int n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      transfer_start_strobe <= 1'b0;
      if (acked) ad_in <= ~a;
      #1;
      if (n == 0) chk(start_hold_flag, 1);
      if (n == 0) chk(latch_open_ctl, 1);
      if (n == 0) chk({tip_oe, addr_oe}, 2'h3);
      acked |= transfer_ack;
      if (tip_out && first < 0) first = n;
      tipc += tip_out;
      dwc += data_wait;
      tsc += ts_out;
      rbc += retry_berr;
      if (first >= 0 && !tip_out) break;
    end
    chk(first, r.s ? 1 : 0);
    chk(tipc, r.w + beats * (r.ws + 1));
    chk(dwc, beats * r.ws);
    chk(tsc, 1);
    chk(rbc, r.eb > 1);
    chk(addr_out, a);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    sys_clk = 0; srst = 1; wait_insert = 0; sync_mode = 0; ad_in = 32'h0;
    xfer_size = 2'h0; transfer_start_strobe = 0; burst_inhibit = 0; bus_grant = 1;
    ws = 2'h0; err_beat = 3'h0; fail_count = 0; num_checks = 0;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({tip_out, latch_open_ctl, ts_out, start_hold_flag}, 0);
    chk(addr_out, ADTG_ADDR_RST);
    foreach (rows[i]) run(rows[i], 32'h8000_0004 ^ (i << 8));
    // Back to back: a second strobe in the final data cycle keeps
    // transfer-active up and must not reopen the latch over the data
    @(posedge sys_clk);
    err_beat <= 3'h0;
    xfer_size <= 2'h0;
    ad_in <= 32'h1234_5678;
    transfer_start_strobe <= 1'b1;
    @(posedge sys_clk);
    ad_in <= 32'h0;
    @(posedge sys_clk);
    transfer_start_strobe <= 1'b0;
    #1;
    chk({tip_out, ts_out}, 2'h3);
    chk(latch_open_ctl, 0);
    chk(addr_out, 32'h1234_5678);
    @(posedge sys_clk);
    #1;
    chk(tip_out, 0);
    // Reset in the middle of a burst cuts it short and leaves all idle
    @(posedge sys_clk);
    xfer_size <= ADTG_SIZE_BURST;
    transfer_start_strobe <= 1'b1;
    @(posedge sys_clk);
    transfer_start_strobe <= 1'b0;
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({tip_out, latch_open_ctl, ts_out, start_hold_flag, data_wait}, 0);
    chk(addr_out, ADTG_ADDR_RST);
    // Strobe without grant is ignored and the pins are released
    @(posedge sys_clk);
    bus_grant <= 1'b0;
    repeat (2) @(posedge sys_clk);
    transfer_start_strobe <= 1'b1;
    @(posedge sys_clk);
    transfer_start_strobe <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk({tip_out, ts_out, tip_oe, addr_oe}, 0);
    tally_and_finish();
  end

  // Hang guard, generous against the fewer than one hundred cycles needed
  initial begin
    #(25 * 4000);
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== verification/adtg_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Board memory answering while the regenerated transfer-active signal is up
module adtg_mem_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       srst,
  // Board view of the bus
  input  wire logic       wait_insert,
  input  wire logic       tip_out,
  // Scenario controls
  input  wire logic [1:0] ws,
  input  wire logic [2:0] err_beat,
  // Answers
  output logic            transfer_ack,
  output logic            transfer_err_ack
);
  logic [5:0] cnt;
  logic [2:0] beat;
  logic [5:0] lat;
  logic [5:0] per;

  // Cycle and beat counts, cleared in bus-idle time
  always_ff @(posedge sys_clk) begin
    if (srst || !tip_out) begin
      cnt  <= 6'h00;
      beat <= 3'h0;
    end else begin
      cnt <= cnt + 6'h01;
      if (transfer_ack) beat <= beat + 3'h1;
    end
  end

  // First transfer-active cycle is an address wait when the strap is set
  always_comb begin
    lat = {5'h00, wait_insert};
    per = {4'h0, ws} + 6'h01;
    transfer_ack = tip_out && (cnt >= lat) && (((cnt - lat) % per) == per - 6'h01);
    transfer_err_ack = transfer_ack && ((beat + 3'h1) == err_beat);
  end
endmodule
`default_nettype wire
